// >>> hw/dbt_pkg.sv
// package: register map, field positions and constants for the breakpoint trigger unit
package dbt_pkg;
   localparam int          DBT_AW          = 12;
   localparam int          DBT_NUM_IB      = 8;
   localparam int          DBT_NUM_DB      = 4;
   // register byte offsets
   localparam logic [11:0] DBT_CTRL_OFF    = 12'h000;
   localparam logic [11:0] DBT_CAUSE_OFF   = 12'h004;
   localparam logic [11:0] DBT_CAUSE2_OFF  = 12'h008;
   localparam logic [11:0] DBT_RETPC_OFF   = 12'h00C;
   localparam logic [11:0] DBT_SCRATCH_OFF = 12'h010;
   localparam logic [11:0] DBT_IRQ_ST_OFF  = 12'h014;
   localparam logic [11:0] DBT_IRQ_MSK_OFF = 12'h018;
   localparam logic [11:0] DBT_IB_BASE     = 12'h100;
   localparam logic [11:0] DBT_DB_BASE     = 12'h200;
   // per-breakpoint word index within its 32-byte slot
   localparam logic [2:0]  DBT_W_ADDR      = 3'h0;
   localparam logic [2:0]  DBT_W_MASK      = 3'h1;
   localparam logic [2:0]  DBT_W_HIGH      = 3'h2;
   localparam logic [2:0]  DBT_W_CTL       = 3'h3;
   localparam logic [2:0]  DBT_W_VALUE     = 3'h4;
   localparam logic [2:0]  DBT_W_PASS      = 3'h5;
   localparam logic [2:0]  DBT_W_PRIME     = 3'h6;
   // breakpoint control fields
   localparam int          DBT_C_EN        = 0;
   localparam int          DBT_C_RANGE     = 1;
   localparam int          DBT_C_OUTSIDE   = 2;
   localparam int          DBT_C_NOLOAD    = 3;
   localparam int          DBT_C_NOSTORE   = 4;
   localparam int          DBT_C_VALUE     = 5;
   localparam int          DBT_C_TUPLE     = 6;
   localparam int          DBT_C_QUAL      = 7;
   localparam int          DBT_C_PASS      = 8;
   localparam int          DBT_C_PRIME     = 9;
   localparam int          DBT_C_BLM_LSB   = 12;
   localparam int          DBT_C_PAIR_LSB  = 16;
   // global control fields
   localparam int          DBT_G_SSTEP     = 0;
   localparam int          DBT_G_DM        = 31;
   // cause register fields
   localparam int          DBT_K_SSTEP     = 0;
   localparam int          DBT_K_IB        = 1;
   localparam int          DBT_K_DB        = 2;
   // interrupt status bits
   localparam int          DBT_I_ENTER     = 0;
   localparam int          DBT_I_LEAVE     = 1;
   localparam logic [31:0] DBT_ZERO        = 32'h0000_0000;
   localparam logic [1:0]  DBT_HTRANS_NSQ  = 2'h2;
   localparam logic [2:0]  DBT_HSIZE_WORD  = 3'h2;
endpackage

// >>> hw/dbt_unit.sv
// breakpoint trigger and debug-mode control unit with AHB-Lite registers
module dbt_unit
   import dbt_pkg::*;
#(
   parameter int NUM_IB  = 8,
   parameter int NUM_DB  = 4,
   parameter bit COMPLEX = 1'b1
) (
   input  wire logic        clk_in,          // core clock
   input  wire logic        rst_b_in,        // async reset, active low
   input  wire logic        hsel_in,         // slave select
   input  wire logic [31:0] haddr_in,        // bus address
   input  wire logic [1:0]  htrans_in,       // transfer type
   input  wire logic        hwrite_in,       // write strobe
   input  wire logic [2:0]  hsize_in,        // transfer size
   input  wire logic [31:0] hwdata_in,       // write data
   input  wire logic        hready_in,       // bus ready
   output logic      [31:0] hrdata_out,      // read data
   output logic             hreadyout_out,   // slave ready
   output logic             hresp_out,       // always okay
   input  wire logic        ex_valid_in,     // instruction executes
   input  wire logic [31:0] ex_pc_in,        // its virtual address
   input  wire logic        ex_is_ls_in,     // instruction is load/store
   input  wire logic        ex_ret_in,       // debug_return_instr executes
   input  wire logic        ls_valid_in,     // load/store access
   input  wire logic        ls_store_in,     // 1 store, 0 load
   input  wire logic [31:0] ls_addr_in,      // access virtual address
   input  wire logic [31:0] ls_data_in,      // operand value
   input  wire logic [3:0]  ls_be_in,        // bytes accessed
   output logic             debug_exc_out,   // take debug exception, pulse
   output logic             debug_mode_out,  // core in debug mode
   output logic [31:0]      debug_pc_out,    // resume address
   output logic             irq_out          // interrupt, level
);
   import dbt_pkg::*;

   function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] base,
                                     input logic [31:0] msk, input logic [31:0] hi,
                                     input logic [31:0] ctl);
      logic inr;
      inr = (a >= base) && (a <= hi);
      if (ctl[DBT_C_RANGE])
         addr_hit = inr ^ ctl[DBT_C_OUTSIDE];
      else
         addr_hit = ((a ^ base) & ~msk) == DBT_ZERO;
   endfunction

   localparam int NB = NUM_IB + NUM_DB;
   // complex features only in the two largest sets
   localparam bit CPLX_EN = COMPLEX && NUM_IB >= 6 && NUM_DB >= 2;

   logic [31:0] bp_addr_reg  [NB];
   logic [31:0] bp_mask_reg  [NB];
   logic [31:0] bp_high_reg  [NB];
   logic [31:0] bp_ctl_reg   [NB];
   logic [31:0] bp_value_reg [NB];
   logic [15:0] bp_pass_reg  [NB];
   logic [NB-1:0] bp_prime_reg [NB];
   logic [NB-1:0] armed_reg;
   logic [NUM_IB-1:0] qual_reg;
   logic [NB-1:0] raw_hit;
   logic [NB-1:0] fire;

   logic [31:0] ctrl_reg, cause_reg, cause2_reg, retpc_reg, scratch_reg;
   logic [1:0]  ist_reg, imsk_reg;
   logic        dm_reg;

   // bus address phase capture
   logic        ap_wr_reg, ap_rd_reg;
   logic [11:0] ap_addr_reg;
   wire  logic  take = hsel_in && hready_in && htrans_in == DBT_HTRANS_NSQ;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ap_wr_reg   <= 1'b0;
         ap_rd_reg   <= 1'b0;
         ap_addr_reg <= 12'h000;
      end else begin
         ap_wr_reg   <= take && hwrite_in && hsize_in == DBT_HSIZE_WORD;
         ap_rd_reg   <= take && !hwrite_in;
         ap_addr_reg <= haddr_in[11:0];
      end
   end

   // bp slot decode: index of the slot or -1
   function automatic int slot_of(input logic [11:0] a);
      slot_of = -1;
      if (a >= DBT_IB_BASE && a < DBT_IB_BASE + 12'(NUM_IB * 32))
         slot_of = int'((a - DBT_IB_BASE) >> 5);
      else if (a >= DBT_DB_BASE && a < DBT_DB_BASE + 12'(NUM_DB * 32))
         slot_of = NUM_IB + int'((a - DBT_DB_BASE) >> 5);
   endfunction

   wire logic signed [31:0] wslot = slot_of(ap_addr_reg);
   wire logic [2:0] wword = ap_addr_reg[4:2];

   // ------------------------------------------------------------
   // comparators
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NB; g++) begin : g_cmp
         if (g < NUM_IB) begin : g_ib
            assign raw_hit[g] = ex_valid_in && !dm_reg && bp_ctl_reg[g][DBT_C_EN] &&
               addr_hit(ex_pc_in, bp_addr_reg[g], bp_mask_reg[g], bp_high_reg[g],
                        bp_ctl_reg[g]);
         end else begin : g_db
            logic [31:0] lane;
            logic        vok;
            always_comb begin
               for (int b = 0; b < 4; b++)
                  lane[8*b +: 8] = {8{ls_be_in[b] && !bp_ctl_reg[g][DBT_C_BLM_LSB+b]}};
               vok = !bp_ctl_reg[g][DBT_C_VALUE] ||
                     ((ls_data_in ^ bp_value_reg[g]) & lane) == DBT_ZERO;
            end
            assign raw_hit[g] = ls_valid_in && !dm_reg && bp_ctl_reg[g][DBT_C_EN] &&
               !(ls_store_in ? bp_ctl_reg[g][DBT_C_NOSTORE] : bp_ctl_reg[g][DBT_C_NOLOAD]) &&
               addr_hit(ls_addr_in, bp_addr_reg[g], bp_mask_reg[g], bp_high_reg[g],
                        bp_ctl_reg[g]) && vok;
         end
      end
   endgenerate

   // complex qualification of each hit
   always_comb begin
      for (int i = 0; i < NB; i++) begin
         logic [31:0] c;
         int          pr;
         c  = bp_ctl_reg[i];
         pr = int'(c[DBT_C_PAIR_LSB +: 4]);
         fire[i] = raw_hit[i];
         if (CPLX_EN) begin
            if (c[DBT_C_TUPLE]) begin
               if (i < NUM_IB)
                  fire[i] = 1'b0;
               else if (pr < NUM_IB)
                  fire[i] = raw_hit[i] && raw_hit[pr] && ex_is_ls_in;
            end
            if (i < NUM_IB && c[DBT_C_QUAL] && !qual_reg[i])
               fire[i] = 1'b0;
            if (c[DBT_C_PRIME] && !armed_reg[i])
               fire[i] = 1'b0;
            if (c[DBT_C_PASS] && bp_pass_reg[i] != 16'h0000)
               fire[i] = 1'b0;
         end
      end
   end

   wire logic brk = |fire;
   wire logic sstep = ctrl_reg[DBT_G_SSTEP] && ex_valid_in && !dm_reg;
   wire logic enter = (brk || sstep) && !dm_reg;
   wire logic leave = dm_reg && ex_ret_in;

   // ------------------------------------------------------------
   // debug mode and state capture
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         dm_reg     <= 1'b0;
         cause_reg  <= DBT_ZERO;
         cause2_reg <= DBT_ZERO;
         retpc_reg  <= DBT_ZERO;
      end else begin
         if (enter) begin
            dm_reg <= 1'b1;
            cause_reg <= DBT_ZERO;
            cause_reg[DBT_K_SSTEP] <= sstep && !brk;
            cause_reg[DBT_K_IB]    <= |fire[NUM_IB-1:0];
            cause_reg[DBT_K_DB]    <= |fire[NB-1:NUM_IB];
            cause2_reg <= 32'(fire);
            retpc_reg  <= ex_pc_in;
         end else if (leave) begin
            dm_reg <= 1'b0;
         end
         if (ap_wr_reg && ap_addr_reg == DBT_RETPC_OFF)
            retpc_reg <= hwdata_in;
      end
   end

   // ------------------------------------------------------------
   // complex state: pass counters, arming, qualification
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         armed_reg <= '0;
         qual_reg  <= '0;
         for (int i = 0; i < NB; i++)
            bp_pass_reg[i] <= 16'h0000;
      end else begin
         for (int i = 0; i < NB; i++) begin
            if (raw_hit[i] && bp_pass_reg[i] != 16'h0000)
               bp_pass_reg[i] <= bp_pass_reg[i] - 16'h0001;
            // arming hit wins over a disarming write
            if (ap_wr_reg && wslot == i && wword == DBT_W_PRIME)
               armed_reg[i] <= 1'b0;
            if ((bp_prime_reg[i] & raw_hit) != '0)
               armed_reg[i] <= 1'b1;
            if (ap_wr_reg && wslot == i && wword == DBT_W_PASS)
               bp_pass_reg[i] <= hwdata_in[15:0];
         end
         for (int j = NUM_IB; j < NB; j++) begin
            int q;
            q = int'(bp_ctl_reg[j][DBT_C_PAIR_LSB +: 4]);
            if (bp_ctl_reg[j][DBT_C_QUAL] && q < NUM_IB && ls_valid_in && !ls_store_in &&
                addr_hit(ls_addr_in, bp_addr_reg[j], bp_mask_reg[j], bp_high_reg[j],
                         bp_ctl_reg[j]))
               qual_reg[q] <= raw_hit[j];
         end
      end
   end

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl_reg    <= DBT_ZERO;
         scratch_reg <= DBT_ZERO;
         imsk_reg    <= 2'h0;
         for (int i = 0; i < NB; i++) begin
            bp_addr_reg[i]  <= DBT_ZERO;
            bp_mask_reg[i]  <= DBT_ZERO;
            bp_high_reg[i]  <= DBT_ZERO;
            bp_ctl_reg[i]   <= DBT_ZERO;
            bp_value_reg[i] <= DBT_ZERO;
            bp_prime_reg[i] <= '0;
         end
      end else if (ap_wr_reg) begin
         case (ap_addr_reg)
            DBT_CTRL_OFF:    ctrl_reg    <= hwdata_in;
            DBT_SCRATCH_OFF: scratch_reg <= hwdata_in;
            DBT_IRQ_MSK_OFF: imsk_reg    <= hwdata_in[1:0];
            default: begin
               for (int i = 0; i < NB; i++) begin
                  if (wslot == i) begin
                     case (wword)
                        DBT_W_ADDR:  bp_addr_reg[i]  <= hwdata_in;
                        DBT_W_MASK:  bp_mask_reg[i]  <= hwdata_in;
                        DBT_W_HIGH:  bp_high_reg[i]  <= hwdata_in;
                        DBT_W_CTL:   bp_ctl_reg[i]   <= hwdata_in;
                        DBT_W_VALUE: bp_value_reg[i] <= hwdata_in;
                        DBT_W_PRIME: bp_prime_reg[i] <= hwdata_in[NB-1:0];
                        default:     bp_addr_reg[i]  <= bp_addr_reg[i];
                     endcase
                  end
               end
            end
         endcase
      end
   end

   // sticky interrupt status, set wins over write-one-clear
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in)
         ist_reg <= 2'h0;
      else
         ist_reg <= (ist_reg & ~((ap_wr_reg && ap_addr_reg == DBT_IRQ_ST_OFF) ?
                    hwdata_in[1:0] : 2'h0)) | {leave, enter};
   end

   // read mux
   logic [31:0] rd;
   always_comb begin
      int s;
      s  = slot_of(ap_addr_reg);
      rd = DBT_ZERO;
      case (ap_addr_reg)
         DBT_CTRL_OFF:    rd = {dm_reg, ctrl_reg[30:0]};
         DBT_CAUSE_OFF:   rd = cause_reg;
         DBT_CAUSE2_OFF:  rd = cause2_reg;
         DBT_RETPC_OFF:   rd = retpc_reg;
         DBT_SCRATCH_OFF: rd = scratch_reg;
         DBT_IRQ_ST_OFF:  rd = {30'h0, ist_reg};
         DBT_IRQ_MSK_OFF: rd = {30'h0, imsk_reg};
         default: begin
            for (int i = 0; i < NB; i++) begin
               if (s == i) begin
                  case (ap_addr_reg[4:2])
                     DBT_W_ADDR:  rd = bp_addr_reg[i];
                     DBT_W_MASK:  rd = bp_mask_reg[i];
                     DBT_W_HIGH:  rd = bp_high_reg[i];
                     DBT_W_CTL:   rd = bp_ctl_reg[i];
                     DBT_W_VALUE: rd = bp_value_reg[i];
                     DBT_W_PASS:  rd = {16'h0, bp_pass_reg[i]};
                     DBT_W_PRIME: rd = 32'(bp_prime_reg[i]);
                     default:     rd = {31'h0, armed_reg[i]};
                  endcase
               end
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         hrdata_out     <= DBT_ZERO;
         hreadyout_out  <= 1'b1;
         hresp_out      <= 1'b0;
         debug_exc_out  <= 1'b0;
         debug_mode_out <= 1'b0;
         debug_pc_out   <= DBT_ZERO;
         irq_out        <= 1'b0;
      end else begin
         hrdata_out     <= take && !hwrite_in ? DBT_ZERO : (ap_rd_reg ? rd : hrdata_out);
         // one wait state on reads: data is registered after the decode
         hreadyout_out  <= !(take && !hwrite_in);
         hresp_out      <= 1'b0;
         debug_exc_out  <= enter;
         debug_mode_out <= dm_reg;
         debug_pc_out   <= retpc_reg;
         irq_out        <= |(ist_reg & imsk_reg);
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_enter_sets_dm: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      enter |=> dm_reg) else $error("debug mode not entered");
   a_ret_clears_dm: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      leave |=> !dm_reg) else $error("debug mode not left");
   a_dm_holds: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      dm_reg && !ex_ret_in |=> dm_reg) else $error("debug mode dropped");
   a_brk_pulse: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      brk && !dm_reg |=> debug_exc_out ##1 debug_mode_out)
      else $error("break not forced");
   a_pass_holds: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      bp_pass_reg[3] == 16'h0000 && !ap_wr_reg |=> bp_pass_reg[3] == 16'h0000)
      else $error("pass counter wrapped");
   a_pass_gate: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      CPLX_EN && bp_ctl_reg[3][DBT_C_PASS] && bp_pass_reg[3] != 16'h0000 |-> !fire[3])
      else $error("fired before count done");
   a_prime_gate: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      CPLX_EN && bp_ctl_reg[5][DBT_C_PRIME] && !armed_reg[5] |-> !fire[5])
      else $error("unarmed breakpoint fired");
   a_retpc_cap: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      enter && !ap_wr_reg |=> retpc_reg == $past(ex_pc_in))
      else $error("return pc not captured");
   a_irq_level: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      enter && imsk_reg[DBT_I_ENTER] && !ap_wr_reg |=> ##1 irq_out)
      else $error("interrupt missing");
endmodule

// >>> test/dbt_pipe_model.sv
// pipeline model: issues executed instructions, load/stores and debug returns
module dbt_pipe_model (
   input  wire logic        clk_in,        // core clock
   output logic             ex_valid_out,  // instruction executes
   output logic [31:0]      ex_pc_out,     // its address
   output logic             ex_is_ls_out,  // it is a load/store
   output logic             ex_ret_out,    // debug return executes
   output logic             ls_valid_out,  // access valid
   output logic             ls_store_out,  // 1 store
   output logic [31:0]      ls_addr_out,   // access address
   output logic [31:0]      ls_data_out,   // operand value
   output logic [3:0]       ls_be_out      // bytes accessed
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {ex_valid_out, ex_is_ls_out, ex_ret_out, ls_valid_out, ls_store_out} = 5'h00;
      {ex_pc_out, ls_addr_out, ls_data_out} = 96'h0;
      ls_be_out = 4'hF;
   end
   // one instruction for one cycle; idle buses show inverted values
   task automatic step(input logic [31:0] pc, input logic isls, input logic st,
                       input logic [31:0] la, input logic [31:0] ld);
      ex_valid_out <= 1'b1;
      ex_pc_out <= pc;
      ex_is_ls_out <= isls;
      ls_valid_out <= isls;
      ls_store_out <= st;
      ls_addr_out <= la;
      ls_data_out <= ld;
      @(posedge clk_in);
      ex_valid_out <= 1'b0;
      ex_is_ls_out <= 1'b0;
      ls_valid_out <= 1'b0;
      ex_pc_out <= ~pc;
      ls_addr_out <= ~la;
      ls_data_out <= ~ld;
   endtask
   task automatic ret_pulse();
      ex_ret_out <= 1'b1;
      @(posedge clk_in);
      ex_ret_out <= 1'b0;
   endtask
endmodule

// >>> test/dbt_unit_tb.sv
// testbench: register bus tasks and breakpoint scenarios for the trigger unit
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module dbt_unit_tb;
   import dbt_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0, rst_b_in = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata_out, debug_pc_out, ex_pc, la, ld;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h0;
   logic [3:0]  be;
   logic hreadyout_out, hresp, debug_exc_out, debug_mode_out, irq_out;
   logic exv, exls, exret, lsv, lsst;
   int miscompares = 0, num_checks = 0, exc_cnt = 0;
   dbt_pipe_model pm (.clk_in(clk_in), .ex_valid_out(exv), .ex_pc_out(ex_pc),
      .ex_is_ls_out(exls), .ex_ret_out(exret), .ls_valid_out(lsv), .ls_store_out(lsst),
      .ls_addr_out(la), .ls_data_out(ld), .ls_be_out(be));
   dbt_unit #(.NUM_IB(8), .NUM_DB(4), .COMPLEX(1'b1)) dut (.clk_in(clk_in),
      .rst_b_in(rst_b_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout_out),
      .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp),
      .ex_valid_in(exv), .ex_pc_in(ex_pc), .ex_is_ls_in(exls), .ex_ret_in(exret),
      .ls_valid_in(lsv), .ls_store_in(lsst), .ls_addr_in(la), .ls_data_in(ld),
      .ls_be_in(be), .debug_exc_out(debug_exc_out), .debug_mode_out(debug_mode_out),
      .debug_pc_out(debug_pc_out), .irq_out(irq_out));
   initial begin
      forever #2.5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      if (debug_exc_out === 1'b1) exc_cnt <= exc_cnt + 1;
   end
   //----------------------------------------
   // bus and pipeline tasks
   //----------------------------------------
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= DBT_HTRANS_NSQ;
      hwrite <= w;
      hsize <= DBT_HSIZE_WORD;
      do @(posedge clk_in); while (hreadyout_out !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_in); while (hreadyout_out !== 1'b1);
      r = hrdata_out;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, {20'h0, a}, d, r);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      ahb(1'b0, {20'h0, a}, 32'h0, r);
      `CHK(r, e)
      `CHK(hresp, 1'b0)
   endtask
   task automatic bw(input logic [11:0] base, input int n, input logic [2:0] w,
                     input logic [31:0] d);
      wr(base + 12'(n * 32) + {7'h0, w, 2'b00}, d);
   endtask
   task automatic leave();
      pm.ret_pulse();
      repeat (3) @(posedge clk_in);
      `CHK(debug_mode_out, 1'b0)
   endtask
   // e: 0 none, 1 break, 2 either, 3 break and stay, 4 none while in debug mode
   task automatic go(input logic [31:0] pc, input logic isls, input logic st,
                     input logic [31:0] a, input logic [31:0] d, input int e);
      int base;
      base = exc_cnt;
      pm.step(pc, isls, st, a, d);
      repeat (3) @(posedge clk_in);
      if (e != 2) begin
         `CHK(exc_cnt - base, int'(e == 1 || e == 3))
         `CHK(debug_mode_out, logic'(e != 0))
      end
      if (e < 3 && debug_mode_out === 1'b1) leave();
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #300us;
      miscompares++;
      wrap_up();
   end
   //----------------------------------------
   // scenarios
   //----------------------------------------
   initial begin
      repeat (6) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(posedge clk_in);
      rc(DBT_CTRL_OFF, DBT_ZERO);
      rc(DBT_RETPC_OFF, DBT_ZERO);
      wr(12'h300, 32'hFFFF_FFFF);
      rc(12'h300, DBT_ZERO);
      wr(DBT_SCRATCH_OFF, 32'hA5A5_5A5A);
      rc(DBT_SCRATCH_OFF, 32'hA5A5_5A5A);
      bw(DBT_IB_BASE, 0, DBT_W_ADDR, 32'h1000);
      bw(DBT_IB_BASE, 0, DBT_W_CTL, 32'h1);
      go(32'h1004, 0, 0, 0, 0, 0);
      go(32'h1000, 0, 0, 0, 0, 3);
      rc(DBT_RETPC_OFF, 32'h1000);
      `CHK(debug_pc_out, 32'h1000)
      rc(DBT_CAUSE_OFF, 32'h1 << DBT_K_IB);
      rc(DBT_CAUSE2_OFF, 32'h1);
      rc(DBT_CTRL_OFF, 32'h1 << DBT_G_DM);
      go(32'h1000, 0, 0, 0, 0, 4);
      leave();
      bw(DBT_IB_BASE, 1, DBT_W_ADDR, 32'h2000);
      bw(DBT_IB_BASE, 1, DBT_W_MASK, 32'hF);
      bw(DBT_IB_BASE, 1, DBT_W_CTL, 32'h1);
      go(32'h200C, 0, 0, 0, 0, 1);
      go(32'h2010, 0, 0, 0, 0, 0);
      bw(DBT_IB_BASE, 2, DBT_W_ADDR, 32'h3000);
      bw(DBT_IB_BASE, 2, DBT_W_HIGH, 32'h3005);
      bw(DBT_IB_BASE, 2, DBT_W_CTL, 32'h3);
      go(32'h3005, 0, 0, 0, 0, 1);
      go(32'h3006, 0, 0, 0, 0, 0);
      bw(DBT_IB_BASE, 2, DBT_W_CTL, 32'h7);
      go(32'h3006, 0, 0, 0, 0, 1);
      go(32'h3003, 0, 0, 0, 0, 0);
      bw(DBT_IB_BASE, 2, DBT_W_CTL, 32'h0);
      bw(DBT_DB_BASE, 0, DBT_W_ADDR, 32'h4000);
      bw(DBT_DB_BASE, 0, DBT_W_CTL, 32'h9);
      go(32'hF00, 1, 0, 32'h4000, 0, 0);
      go(32'hF00, 1, 1, 32'h4000, 0, 1);
      bw(DBT_DB_BASE, 0, DBT_W_CTL, 32'h11);
      go(32'hF00, 1, 1, 32'h4000, 0, 0);
      go(32'hF00, 1, 0, 32'h4000, 0, 1);
      bw(DBT_DB_BASE, 0, DBT_W_MASK, 32'hFF);
      bw(DBT_DB_BASE, 0, DBT_W_CTL, 32'h1);
      go(32'hF00, 1, 0, 32'h40F0, 0, 1);
      bw(DBT_DB_BASE, 0, DBT_W_VALUE, 32'h1122_3344);
      bw(DBT_DB_BASE, 0, DBT_W_CTL, 32'h1021);
      go(32'hF00, 1, 0, 32'h4010, 32'h1122_33FF, 1);
      go(32'hF00, 1, 0, 32'h4010, 32'h0022_33FF, 0);
      bw(DBT_DB_BASE, 0, DBT_W_CTL, 32'h0);
      bw(DBT_IB_BASE, 3, DBT_W_ADDR, 32'h5000);
      bw(DBT_IB_BASE, 3, DBT_W_PASS, 32'h2);
      bw(DBT_IB_BASE, 3, DBT_W_CTL, 32'h101);
      go(32'h5000, 0, 0, 0, 0, 0);
      go(32'h5000, 0, 0, 0, 0, 0);
      go(32'h5000, 0, 0, 0, 0, 1);
      go(32'h5000, 0, 0, 0, 0, 1);
      bw(DBT_IB_BASE, 3, DBT_W_CTL, 32'h0);
      rc(DBT_IB_BASE + 12'h60 + 12'h14, DBT_ZERO);
      bw(DBT_IB_BASE, 4, DBT_W_ADDR, 32'h6000);
      bw(DBT_IB_BASE, 4, DBT_W_CTL, 32'h41);
      bw(DBT_DB_BASE, 1, DBT_W_ADDR, 32'h7000);
      bw(DBT_DB_BASE, 1, DBT_W_CTL, 32'h4_0041);
      go(32'h6000, 1, 0, 32'h7000, 0, 1);
      go(32'h6000, 1, 0, 32'h7004, 0, 0);
      go(32'h6004, 1, 0, 32'h7000, 0, 0);
      go(32'h6000, 0, 0, 0, 0, 0);
      bw(DBT_IB_BASE, 5, DBT_W_ADDR, 32'h8000);
      bw(DBT_IB_BASE, 5, DBT_W_PRIME, 32'h40);
      bw(DBT_IB_BASE, 5, DBT_W_CTL, 32'h201);
      bw(DBT_IB_BASE, 6, DBT_W_ADDR, 32'h8100);
      bw(DBT_IB_BASE, 6, DBT_W_CTL, 32'h1);
      go(32'h8000, 0, 0, 0, 0, 0);
      go(32'h8100, 0, 0, 0, 0, 1);
      go(32'h8000, 0, 0, 0, 0, 1);
      bw(DBT_IB_BASE, 7, DBT_W_ADDR, 32'h9000);
      bw(DBT_IB_BASE, 7, DBT_W_CTL, 32'h81);
      bw(DBT_DB_BASE, 2, DBT_W_ADDR, 32'hA000);
      bw(DBT_DB_BASE, 2, DBT_W_VALUE, 32'h55);
      bw(DBT_DB_BASE, 2, DBT_W_CTL, 32'h7_00A1);
      go(32'hF00, 1, 0, 32'hA000, 32'h55, 1);
      go(32'h9000, 0, 0, 0, 0, 1);
      go(32'hF00, 1, 0, 32'hA000, 32'h66, 0);
      go(32'h9000, 0, 0, 0, 0, 0);
      wr(DBT_IRQ_ST_OFF, 32'h3);
      wr(DBT_IRQ_MSK_OFF, 32'h1);
      repeat (2) @(posedge clk_in);
      `CHK(irq_out, 1'b0)
      wr(DBT_CTRL_OFF, 32'h1 << DBT_G_SSTEP);
      go(32'hF04, 0, 0, 0, 0, 3);
      rc(DBT_CAUSE_OFF, 32'h1 << DBT_K_SSTEP);
      `CHK(irq_out, 1'b1)
      wr(DBT_CTRL_OFF, DBT_ZERO);
      wr(DBT_IRQ_ST_OFF, 32'h1);
      repeat (2) @(posedge clk_in);
      `CHK(irq_out, 1'b0)
      leave();
      repeat (2) @(posedge clk_in);
      `CHK(irq_out, 1'b0)
      rc(DBT_IRQ_ST_OFF, 32'h1 << DBT_I_LEAVE);
      go(32'hF08, 0, 0, 0, 0, 0);
      wrap_up();
   end
endmodule
